// ### pkg/smf_pkg.sv
// smf_pkg: constants shared by both ends of the serial memory link.
// assumes: both ends import the whole package in their headers.
package smf_pkg;
  // ---------------------------------------------------------------
  // memory geometry
  // ---------------------------------------------------------------
  localparam int MEM_ADDR_W = 11;
  localparam int MEM_DEPTH = 2048;
  localparam int LINK_ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // ---------------------------------------------------------------
  // command opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  // ---------------------------------------------------------------
  // status register layout and block protection bounds
  // ---------------------------------------------------------------
  localparam int SR_WEL = 1;
  localparam int SR_BP0 = 2;
  localparam int SR_BP1 = 3;
  localparam int SR_WPEN = 7;
  localparam logic [10:0] PROT_QUARTER = 11'h600;
  localparam logic [10:0] PROT_HALF = 11'h400;
  // ---------------------------------------------------------------
  // host timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int SCK_HALF_CYC = 4;
  localparam int PU_DELAY_NS = 1000;
  localparam int PU_DELAY_CYC = (PU_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int FRAME_BITS_LONG = 32;
  localparam int FRAME_BITS_MID = 16;
  localparam int FRAME_BITS_SHORT = 8;
endpackage : smf_pkg

// ### pkg/smf_spi_if.sv
// smf_spi_if: the four-wire serial link plus hold and write protect.
// assumes: no pull device beyond this file; an undriven output reads 1.
`timescale 1ns/1ps
interface smf_spi_if;
  logic cs_n;     // chip select, active low
  logic sck;      // serial clock from the host
  logic mosi;     // host to device data
  logic miso;     // device output value
  logic miso_oe;  // device drives miso while high
  logic hold_n;   // suspend, active low
  logic wp_n;     // write protect, active low
  logic miso_line;

  // released line reads 1 here; this assign stands in for a pull-up
  assign miso_line = miso_oe ? miso : 1'b1;

  modport dev (input cs_n, sck, mosi, hold_n, wp_n, output miso, miso_oe);
  modport host (output cs_n, sck, mosi, hold_n, wp_n, input miso_line);
endinterface : smf_spi_if

// ### hdl/smf_dev.sv
// smf_dev: slave end of the serial memory link with its 2K x 8 array.
// assumes: sck and cs_n come from the host; clk is the user domain that
// receives write notices and the latched clock mode.
`timescale 1ns/1ps
module smf_dev
  import smf_pkg::*;
#(
  parameter int ADDR_W = MEM_ADDR_W,
  parameter int DEPTH = MEM_DEPTH
) (
  smf_spi_if.dev spi,                  // serial link
  input wire logic clk,                // user clock
  input wire logic sys_rst,            // async reset, active high
  output logic wr_pulse,               // one clk pulse per stored byte
  output logic [ADDR_W-1:0] wr_addr,   // address of stored byte
  output logic [BYTE_W-1:0] wr_data,   // value of stored byte
  output logic mode3                   // clock mode latched at select
);
  // ---------------------------------------------------------------
  // types and helpers
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_OPC = 5'h01,
    ST_ADH = 5'h02,
    ST_ADL = 5'h04,
    ST_DATA = 5'h08,
    ST_IGN = 5'h10
  } smf_dst_t;

  // the six opcodes that the device acts on
  function automatic logic op_known(input logic [7:0] op);
    return op == OP_WREN || op == OP_WRDI || op == OP_RDSR ||
           op == OP_WRSR || op == OP_READ || op == OP_WRITE;
  endfunction : op_known

  // block protection from the two protect bits
  function automatic logic blk_prot(input logic [ADDR_W-1:0] a,
                                    input logic [1:0] bp);
    logic r;
    r = 1'b0;
    unique case (bp)
      2'h0: r = 1'b0;
      2'h1: r = a >= PROT_QUARTER;
      2'h2: r = a >= PROT_HALF;
      2'h3: r = 1'b1;
    endcase
    return r;
  endfunction : blk_prot

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [BYTE_W-1:0] mem [DEPTH];
  smf_dst_t state;
  logic [2:0] bcnt;
  logic [6:0] shin;
  logic [7:0] opcode;
  logic [ADDR_W-1:0] addr;
  logic [7:0] rd_byte;
  logic wel, wpen;
  logic [1:0] bp;
  logic pend_set, pend_clr, pend_sr_we;
  logic [7:0] pend_sr;
  logic wr_tgl;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic mode_lat;
  logic tgl_s1, tgl_s2, tgl_s3;
  logic mode_s1;

  // ---------------------------------------------------------------
  // decoding
  // ---------------------------------------------------------------
  wire frame_rst = spi.cs_n | sys_rst;
  wire run = spi.hold_n;
  wire byte_done = run && bcnt == BIT_LAST;
  wire [7:0] rx_byte = {shin, spi.mosi};
  wire [7:0] status = {wpen, 3'h0, bp, wel, 1'b0};
  wire in_data = state == ST_DATA;
  wire is_read = in_data && opcode == OP_READ;
  wire is_rdsr = in_data && opcode == OP_RDSR;
  wire mem_ok = wel && !blk_prot(addr, bp);
  wire mem_we = !spi.cs_n && byte_done && in_data &&
                opcode == OP_WRITE && mem_ok;
  wire sr_ok = wel && !(wpen && !spi.wp_n);
  wire frame_first = run && state == ST_OPC && bcnt == 3'h0;
  wire [ADDR_W-1:0] addr_inc = ADDR_W'(addr + 1'b1);
  wire [ADDR_W-1:0] addr_full = {addr[ADDR_W-1:8], rx_byte};

  // ---------------------------------------------------------------
  // framing on rising sck; deselect returns to the opcode bit 0
  // ---------------------------------------------------------------
  always_ff @(posedge spi.sck or posedge frame_rst) begin
    if (frame_rst) begin
      bcnt <= 3'h0;
      shin <= 7'h00;
      state <= ST_OPC;
      opcode <= 8'h00;
      addr <= '0;
      rd_byte <= 8'h00;
    end else if (run) begin
      bcnt <= bcnt + 3'h1;
      shin <= rx_byte[6:0];
      if (byte_done) begin
        unique case (state)
          ST_OPC: begin
            opcode <= rx_byte;
            rd_byte <= status;
            if (!op_known(rx_byte)) begin
              state <= ST_IGN;
            end else if (rx_byte == OP_READ || rx_byte == OP_WRITE) begin
              state <= ST_ADH;
            end else if (rx_byte == OP_RDSR || rx_byte == OP_WRSR) begin
              state <= ST_DATA;
            end else begin
              state <= ST_IGN;
            end
          end
          ST_ADH: begin
            // the five upper bits are dropped here
            addr[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0];
            state <= ST_ADL;
          end
          ST_ADL: begin
            addr[7:0] <= rx_byte;
            rd_byte <= mem[addr_full];
            state <= ST_DATA;
          end
          ST_DATA: begin
            // sequential access wraps at the top of the array
            addr <= addr_inc;
            rd_byte <= is_rdsr ? status : mem[addr_inc];
            if (opcode == OP_WRSR) begin
              state <= ST_IGN;
            end
          end
          ST_IGN: begin
            state <= ST_IGN;
          end
        endcase
      end
    end
  end

  // array write; not reset so that contents survive deselect
  always_ff @(posedge spi.sck) begin
    if (mem_we) begin
      mem[addr] <= rx_byte;
    end
  end

  // ---------------------------------------------------------------
  // output on falling sck, released unless returning read data
  // ---------------------------------------------------------------
  always_ff @(negedge spi.sck or posedge frame_rst) begin
    if (frame_rst) begin
      spi.miso_oe <= 1'b0;
      spi.miso <= 1'b0;
    end else begin
      spi.miso_oe <= run && (is_read || is_rdsr);
      spi.miso <= rd_byte[~bcnt];
    end
  end

  // ---------------------------------------------------------------
  // status changes collected during the frame, applied at deselect
  // ---------------------------------------------------------------
  always_ff @(posedge spi.sck or posedge sys_rst) begin
    if (sys_rst) begin
      pend_set <= 1'b0;
      pend_clr <= 1'b0;
      pend_sr_we <= 1'b0;
      pend_sr <= 8'h00;
    end else if (frame_first) begin
      pend_set <= 1'b0;
      pend_clr <= 1'b0;
      pend_sr_we <= 1'b0;
    end else if (byte_done && state == ST_OPC) begin
      pend_set <= rx_byte == OP_WREN;
      pend_clr <= rx_byte == OP_WRDI || rx_byte == OP_WRSR ||
                  rx_byte == OP_WRITE;
    end else if (byte_done && in_data && opcode == OP_WRSR) begin
      pend_sr_we <= sr_ok;
      pend_sr <= rx_byte;
    end
  end

  // a frame with no clock edges simply applies the same pending set again
  always_ff @(posedge spi.cs_n or posedge sys_rst) begin
    if (sys_rst) begin
      wel <= 1'b0;
      wpen <= 1'b0;
      bp <= 2'h0;
    end else begin
      if (pend_sr_we) begin
        wpen <= pend_sr[SR_WPEN];
        bp <= {pend_sr[SR_BP1], pend_sr[SR_BP0]};
      end
      if (pend_set) begin
        wel <= 1'b1;
      end else if (pend_clr) begin
        wel <= 1'b0;
      end
    end
  end

  // clock level at the select edge decides the mode
  always_ff @(negedge spi.cs_n or posedge sys_rst) begin
    if (sys_rst) begin
      mode_lat <= 1'b0;
    end else begin
      mode_lat <= spi.sck;
    end
  end

  // ---------------------------------------------------------------
  // write notice crossing into clk: toggle plus held data
  // ---------------------------------------------------------------
  always_ff @(posedge spi.sck or posedge sys_rst) begin
    if (sys_rst) begin
      wr_tgl <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= 8'h00;
    end else if (mem_we) begin
      wr_tgl <= ~wr_tgl;
      wr_addr_q <= addr;
      wr_data_q <= rx_byte;
    end
  end

  // held words are stable for eight sck periods after each toggle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      mode_s1 <= 1'b0;
      mode3 <= 1'b0;
      wr_pulse <= 1'b0;
      wr_addr <= '0;
      wr_data <= 8'h00;
    end else begin
      tgl_s1 <= wr_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      mode_s1 <= mode_lat;
      mode3 <= mode_s1;
      wr_pulse <= tgl_s2 ^ tgl_s3;
      if (tgl_s2 ^ tgl_s3) begin
        wr_addr <= wr_addr_q;
        wr_data <= wr_data_q;
      end
    end
  end
endmodule : smf_dev

// ### hdl/smf_host.sv
// smf_host: master end; runs one command per select on its own clock.
// assumes: clk is the only clock here; sck is divided down from it.
`timescale 1ns/1ps
module smf_host
  import smf_pkg::*;
#(
  parameter int HALF = SCK_HALF_CYC,
  parameter int PU_CYC = PU_DELAY_CYC
) (
  smf_spi_if.host spi,                 // serial link
  input wire logic clk,                // 40 MHz clock
  input wire logic sys_rst,            // async reset, active high
  input wire logic cmd_valid,          // command offered
  output logic cmd_ready,              // command taken when both high
  input wire logic [7:0] cmd_op,       // opcode
  input wire logic [15:0] cmd_addr,    // byte address
  input wire logic [7:0] cmd_wdata,    // data or status value to send
  input wire logic cmd_mode3,          // 1 selects clock mode 3
  output logic rsp_valid,              // one pulse at frame end
  output logic [7:0] rsp_data          // last byte received
);
  // ---------------------------------------------------------------
  // types and helpers
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    H_PWR = 5'h01,
    H_IDLE = 5'h02,
    H_SETUP = 5'h04,
    H_SHIFT = 5'h08,
    H_GAP = 5'h10
  } smf_hst_t;

  // bits in a frame for each opcode
  function automatic logic [5:0] frame_bits(input logic [7:0] op);
    logic [5:0] n;
    n = 6'(FRAME_BITS_SHORT);
    if (op == OP_READ || op == OP_WRITE) begin
      n = 6'(FRAME_BITS_LONG);
    end else if (op == OP_RDSR || op == OP_WRSR) begin
      n = 6'(FRAME_BITS_MID);
    end
    return n;
  endfunction : frame_bits

  smf_hst_t state;
  logic [15:0] pu_cnt;
  logic [7:0] half_cnt;
  logic hi;
  logic idle_lvl;
  logic [5:0] bits_left;
  logic [31:0] shreg;
  logic [7:0] rx;
  logic miso_s1, miso_s2;

  // ---------------------------------------------------------------
  // decoding
  // ---------------------------------------------------------------
  wire half_end = half_cnt == 8'(HALF - 1);
  wire take = state == H_IDLE && cmd_ready && cmd_valid;
  wire long_op = cmd_op == OP_READ || cmd_op == OP_WRITE;
  // upper address bits forced to zero for larger parts
  wire [15:0] addr_z = {5'h00, cmd_addr[MEM_ADDR_W-1:0]};
  wire [31:0] frame_word = long_op ? {cmd_op, addr_z, cmd_wdata} :
                           {cmd_op, cmd_wdata, 16'h0000};

  // miso is another party's pin: two flops before use
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      miso_s1 <= 1'b1;
      miso_s2 <= 1'b1;
    end else begin
      miso_s1 <= spi.miso_line;
      miso_s2 <= miso_s1;
    end
  end

  // ---------------------------------------------------------------
  // frame sequencer; half periods of HALF clk cycles each
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= H_PWR;
      pu_cnt <= 16'h0000;
      half_cnt <= 8'h00;
      hi <= 1'b0;
      idle_lvl <= 1'b0;
      bits_left <= 6'h00;
      shreg <= 32'h0000_0000;
      rx <= 8'h00;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      spi.cs_n <= 1'b1;
      spi.sck <= 1'b0;
      spi.mosi <= 1'b0;
      spi.hold_n <= 1'b1;
      spi.wp_n <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      half_cnt <= half_end ? 8'h00 : half_cnt + 8'h01;
      unique case (state)
        H_PWR: begin
          // no select before the access delay has passed
          pu_cnt <= pu_cnt + 16'h0001;
          if (pu_cnt == 16'(PU_CYC)) begin
            state <= H_IDLE;
            cmd_ready <= 1'b1;
          end
        end
        H_IDLE: begin
          spi.sck <= cmd_mode3;
          if (take) begin
            cmd_ready <= 1'b0;
            idle_lvl <= cmd_mode3;
            spi.mosi <= frame_word[31];
            shreg <= frame_word;
            bits_left <= frame_bits(cmd_op);
            half_cnt <= 8'h00;
            state <= H_SETUP;
          end
        end
        H_SETUP: begin
          // select a cycle after sck settles, so the mode level is clean
          spi.cs_n <= 1'b0;
          if (half_end) begin
            spi.sck <= 1'b0;             // mode 3 leaves its high idle
            hi <= 1'b0;
            state <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (half_end && !hi) begin
            spi.sck <= 1'b1;
            hi <= 1'b1;
          end else if (half_end) begin
            // device output is steady through the high half
            rx <= {rx[6:0], miso_s2};
            bits_left <= bits_left - 6'h01;
            if (bits_left == 6'h01) begin
              spi.sck <= idle_lvl;
              state <= H_GAP;
            end else begin
              spi.sck <= 1'b0;
              hi <= 1'b0;
              shreg <= {shreg[30:0], 1'b0};
              spi.mosi <= shreg[30];
            end
          end
        end
        H_GAP: begin
          if (half_end) begin
            spi.cs_n <= 1'b1;
            rsp_valid <= 1'b1;
            rsp_data <= rx;
            cmd_ready <= 1'b1;
            state <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule : smf_host

// ### verification/smf_chk.sv
// smf_chk: link checks beside the interface joining host and device.
// assumes: sck and cs_n are made by the host from clk, so clk samples them.
`timescale 1ns/1ps
module smf_chk
  import smf_pkg::*;
(
  input wire logic clk,     // host clock
  input wire logic sys_rst, // async reset, active high
  input wire logic cs_n,    // chip select, active low
  input wire logic sck,     // serial clock
  input wire logic mosi,    // host data
  input wire logic miso,    // device data value
  input wire logic miso_oe, // device drive enable
  input wire logic hold_n,  // suspend, active low
  input wire logic wp_n     // write protect, active low
);
  // ---------------------------------------------------------------
  // frame tracking
  // ---------------------------------------------------------------
  logic sck_q;
  logic [5:0] rises;
  logic [7:0] op;
  wire sck_up = sck && !sck_q;

  // rises are counted per select; the opcode is kept from the first eight
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_q <= 1'b0;
      rises <= 6'h00;
      op <= 8'h00;
    end else begin
      sck_q <= sck;
      if (cs_n) begin
        rises <= 6'h00;
      end else if (sck_up) begin
        rises <= rises + 6'h01;
        if (rises < 6'h08) begin
          op <= {op[6:0], mosi};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_desel_quiet: assert property (cs_n |-> !miso_oe)
    else $error("miso driven while deselected");
  a_oe_on_fall: assert property ($rose(miso_oe) |-> $fell(sck))
    else $error("miso drive began off a falling sck");
  a_miso_on_fall: assert property
    (miso_oe && $past(miso_oe) && $changed(miso) |-> $fell(sck))
    else $error("miso changed off a falling sck");
  a_mosi_at_rise: assert property
    (!cs_n && $rose(sck) |-> $stable(mosi))
    else $error("mosi moved at a rising sck");
  a_oe_start: assert property ($rose(miso_oe) |->
    (op == OP_READ && rises == 6'h18) || (op == OP_RDSR && rises == 6'h08))
    else $error("miso driven outside read data");
  a_frame_len: assert property ($rose(cs_n) |->
    rises == 6'h08 || rises == 6'h10 || rises == 6'h20)
    else $error("frame ended on a partial byte");
  a_sck_idle: assert property ($fell(cs_n) |-> $stable(sck)[*3])
    else $error("sck moved at select");
  a_hold_wp_up: assert property (hold_n && wp_n)
    else $error("hold or write protect driven low");

  c_long_frame: cover property ($rose(cs_n) && rises == 6'h20);
  c_read_data: cover property ($rose(miso_oe));
  c_mode3_sel: cover property ($fell(cs_n) && sck);
endmodule : smf_chk

// ### verification/serial_memory_spi_slave_frontend_tb.sv
// serial_memory_spi_slave_frontend_tb: host and device facing each other,
// plus a second device driven bit by bit to break host-side rules.
// assumes: smf_pkg, smf_spi_if, smf_host, smf_dev and smf_chk compiled.
`timescale 1ns/1ps
module serial_memory_spi_slave_frontend_tb;
  import smf_pkg::*;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic clk, sys_rst, cmd_valid, cmd_ready, cmd_mode3, rsp_valid;
  logic [7:0] cmd_op, cmd_wdata, rsp_data, wr_data, wr_data_b;
  logic [15:0] cmd_addr;
  logic [10:0] wr_addr, wr_addr_b;
  logic wr_pulse, wr_pulse_b, mode3, oe_b_seen;
  int errors, n_tests, wr_cnt, wr_cnt_b;
  smf_spi_if spi();
  smf_spi_if spi2();

  smf_host #(.HALF(4), .PU_CYC(4)) u_smf_host (.spi(spi.host), .clk(clk),
    .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_mode3(cmd_mode3), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  smf_dev u_smf_dev (.spi(spi.dev), .clk(clk), .sys_rst(sys_rst),
    .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data), .mode3(mode3));
  smf_dev u_smf_dev_b (.spi(spi2.dev), .clk(clk), .sys_rst(sys_rst),
    .wr_pulse(wr_pulse_b), .wr_addr(wr_addr_b), .wr_data(wr_data_b),
    .mode3());
  smf_chk u_smf_chk (.clk(clk), .sys_rst(sys_rst), .cs_n(spi.cs_n),
    .sck(spi.sck), .mosi(spi.mosi), .miso(spi.miso),
    .miso_oe(spi.miso_oe), .hold_n(spi.hold_n), .wp_n(spi.wp_n));

  // clock, store counters and a watch on the second device's output
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (wr_pulse === 1'b1) wr_cnt++;
  always @(posedge clk) if (wr_pulse_b === 1'b1) wr_cnt_b++;
  always @(posedge spi2.miso_oe) oe_b_seen = 1'b1;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  // one host command; entered just after a clock edge
  task automatic run_cmd(input logic [7:0] op, input logic [15:0] a,
      input logic [7:0] wd, input logic m3, output logic [7:0] rd);
    int n;
    n = 0;
    #1 cmd_op = op;
    cmd_addr = a;
    cmd_wdata = wd;
    cmd_mode3 = m3;
    cmd_valid = 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 400);
    #1 cmd_valid = 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 800);
    if (rsp_valid !== 1'b1) errors++;
    rd = rsp_data;
  endtask : run_cmd

  // the bench plays host on the second link; sck period is 160 ns
  task automatic bb_frame(input logic [31:0] v, input int n);
    spi2.cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      spi2.sck = 1'b0;
      spi2.mosi = v[i];
      #80 spi2.sck = 1'b1;
      #80;
    end
    spi2.sck = 1'b0;
    #80 spi2.cs_n = 1'b1;
    spi2.mosi = ~spi2.mosi;
    #160;
  endtask : bb_frame

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_write_read(input logic [15:0] a, input logic [7:0] d,
      input logic m3);
    logic [7:0] rd;
    int tgt;
    tgt = wr_cnt + 1;
    run_cmd(OP_WREN, 16'h0000, 8'h00, m3, rd);
    run_cmd(OP_RDSR, 16'h0000, 8'h00, m3, rd);
    check(rd, 8'h02);
    run_cmd(OP_WRITE, a, d, m3, rd);
    repeat (20) if (wr_cnt != tgt) @(posedge clk);
    check(16'(wr_cnt), 16'(tgt));
    check(wr_addr, a[10:0]);
    check(wr_data, d);
    // read straight after the answer, no pause for a busy device
    run_cmd(OP_READ, a, 8'h00, m3, rd);
    check(rd, d);
    check(mode3, m3);
    run_cmd(OP_RDSR, 16'h0000, 8'h00, m3, rd);
    check(rd, 8'h00);
  endtask : t_write_read

  task automatic t_bad_op();
    logic [7:0] rd;
    run_cmd(8'hFF, 16'h1234, 8'h00, 1'b0, rd);
    check(rd, 8'hFF);
    check(mode3, 1'b0);
  endtask : t_bad_op

  // status writes: disable, then protect everything and try a store
  task automatic t_status();
    logic [7:0] rd;
    int tgt;
    tgt = wr_cnt;
    run_cmd(OP_WREN, 16'h0000, 8'h00, 1'b0, rd);
    run_cmd(OP_WRDI, 16'h0000, 8'h00, 1'b0, rd);
    run_cmd(OP_RDSR, 16'h0000, 8'h00, 1'b0, rd);
    check(rd, 8'h00);
    run_cmd(OP_WREN, 16'h0000, 8'h00, 1'b0, rd);
    run_cmd(OP_WRSR, 16'h0000, 8'h8C, 1'b0, rd);
    run_cmd(OP_RDSR, 16'h0000, 8'h00, 1'b0, rd);
    check(rd, 8'h8C);
    run_cmd(OP_WREN, 16'h0000, 8'h00, 1'b0, rd);
    run_cmd(OP_WRITE, 16'h0010, 8'h77, 1'b0, rd);
    repeat (20) @(posedge clk);
    check(16'(wr_cnt), 16'(tgt));
    run_cmd(OP_WREN, 16'h0000, 8'h00, 1'b0, rd);
    run_cmd(OP_WRSR, 16'h0000, 8'h00, 1'b0, rd);
    run_cmd(OP_RDSR, 16'h0000, 8'h00, 1'b0, rd);
    check(rd, 8'h00);
  endtask : t_status

  // upper address bits set on purpose, then a bad opcode with trailing bits
  task automatic t_raw_link();
    int tgt;
    tgt = wr_cnt_b + 1;
    bb_frame(32'(OP_WREN), 8);
    bb_frame({OP_WRITE, 16'hF812, 8'h5A}, 32);
    repeat (20) if (wr_cnt_b != tgt) @(posedge clk);
    check(16'(wr_cnt_b), 16'(tgt));
    check(wr_addr_b, 11'h012);
    check(wr_data_b, 8'h5A);
    // hold low through a whole enable-and-store sequence: nothing lands
    spi2.hold_n = 1'b0;
    bb_frame(32'(OP_WREN), 8);
    bb_frame({OP_WRITE, 16'h0034, 8'h66}, 32);
    spi2.hold_n = 1'b1;
    repeat (20) @(posedge clk);
    check(16'(wr_cnt_b), 16'(tgt));
    bb_frame({8'hA0, 24'hFFFFFF}, 32);
    check(oe_b_seen, 1'b0);
    check(16'(wr_cnt_b), 16'(tgt));
  endtask : t_raw_link

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    errors = 0;
    n_tests = 0;
    wr_cnt = 0;
    wr_cnt_b = 0;
    oe_b_seen = 1'b0;
    sys_rst = 1'b1;
    {cmd_valid, cmd_mode3, cmd_op, cmd_wdata, cmd_addr} = '0;
    {spi2.cs_n, spi2.sck, spi2.mosi, spi2.hold_n, spi2.wp_n} = 5'h13;
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    @(posedge clk);
    t_write_read(16'h07FF, 8'hA5, 1'b0);
    t_write_read(16'h0400, 8'h3C, 1'b1);
    t_bad_op();
    t_status();
    t_raw_link();
    results();
  end

  // the whole run needs about 4000 clock cycles
  initial begin
    #400000;
    errors++;
    results();
  end
endmodule : serial_memory_spi_slave_frontend_tb
